// [common/sfi_pkg.sv]
// Purpose: shared constants and types of the status flag instruction unit
// Assumes: 8-bit status register, word-addressed avalon-mm slave
// Notes:   register byte offsets are four times the word index
package sfi_pkg;

   // data widths
   localparam int DATA_W    = 8;
   localparam int BIT_IDX_W = 3;
   localparam int BUS_W     = 32;
   localparam int ADDR_W    = 2;
   localparam int BE_W      = 4;
   localparam int OP_W      = 5;

   // status flag bit positions
   localparam logic [2:0] FLAG_C = 3'h0;
   localparam logic [2:0] FLAG_Z = 3'h1;
   localparam logic [2:0] FLAG_N = 3'h2;
   localparam logic [2:0] FLAG_V = 3'h3;
   localparam logic [2:0] FLAG_S = 3'h4;
   localparam logic [2:0] FLAG_H = 3'h5;
   localparam logic [2:0] FLAG_T = 3'h6;
   localparam logic [2:0] FLAG_I = 3'h7;

   // reset values
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [7:0] COUNT_RESET  = 8'h00;

   // register word indices (byte offsets 0x0, 0x4, 0x8)
   localparam logic [1:0] REG_STATUS_IDX = 2'h0;
   localparam logic [1:0] REG_CTRL_IDX   = 2'h1;
   localparam logic [1:0] REG_INFO_IDX   = 2'h2;

   // control register fields
   localparam int CTRL_DEBUG_EN_BIT = 0;

   // info register fields
   localparam int INFO_OP_LSB    = 0;
   localparam int INFO_COUNT_LSB = 8;

   // instruction set handled by the unit
   typedef enum logic [OP_W-1:0] {
      OP_IDLE,
      OP_SET_BY_INDEX,
      OP_CLEAR_BY_INDEX,
      OP_SET_CARRY,
      OP_CLEAR_CARRY,
      OP_SET_NEGATIVE,
      OP_CLEAR_NEGATIVE,
      OP_SET_ZERO,
      OP_CLEAR_ZERO,
      OP_IRQ_ON,
      OP_IRQ_OFF,
      OP_SET_SIGN,
      OP_CLEAR_SIGN,
      OP_SET_OVERFLOW,
      OP_CLEAR_OVERFLOW,
      OP_SET_TRANSFER,
      OP_CLEAR_TRANSFER,
      OP_SET_HALF_CARRY,
      OP_CLEAR_HALF_CARRY,
      OP_COPY_BIT,
      OP_LOAD_BIT,
      OP_SLEEP,
      OP_WATCHDOG_RESTART,
      OP_BREAK
   } sfi_op_t;

endpackage

// [hdl/sfi_bit_unit.sv]
// Purpose: picks one bit of a register and inserts the transfer flag
// Assumes: purely combinational, same clock domain as the caller
// Notes:   one generate slice per data bit
`timescale 1ns/1ps
module sfi_bit_unit (
   // operand
   input  wire logic [sfi_pkg::DATA_W-1:0]    src_data,
   input  wire logic [sfi_pkg::BIT_IDX_W-1:0] bit_idx,
   input  wire logic                          transfer_flag,
   // results
   output logic                               picked_bit,
   output logic      [sfi_pkg::DATA_W-1:0]    merged_data
);
   import sfi_pkg::*;

   logic [DATA_W-1:0] sel_onehot;

   genvar g;
   generate
      for (g = 0; g < DATA_W; g++) begin : g_bit
         // one slice selects or replaces bit g
         assign sel_onehot[g]  = (bit_idx == BIT_IDX_W'(g));
         assign merged_data[g] = sel_onehot[g] ? transfer_flag : src_data[g];
      end
   endgenerate

   assign picked_bit = |(src_data & sel_onehot);

endmodule

// [hdl/sfi_core.sv]
// Purpose: executes status flag and miscellaneous control instructions
// Assumes: decoder presents one instruction per op_valid cycle
// Notes:   status, control and info registers reachable over avalon-mm
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps

// Function
// RQ1 - bit copy moves chosen source bit into transfer flag, one clock only
// RQ2 - bit load writes transfer flag into chosen result bit, flags unchanged
// RQ3 - set sign forces signed test flag high in one clock, nothing else
// RQ4 - clear sign forces signed test flag low in one clock, nothing else
// RQ5 - set overflow forces overflow flag high in one clock, others kept
// RQ6 - clear overflow forces overflow flag low in one clock, others kept
// RQ7 - set half carry forces half carry flag high in one clock
// RQ8 - clear half carry forces half carry flag low in one clock
// RQ9 - sleep takes one clock, keeps flags, raises sleep request pulse
// RQ10 - watchdog restart takes one clock, keeps flags, pulses restart
// RQ11 - break acts only with debug enabled, keeps flags, no fixed length
// RQ12 - dedicated and indexed flag ops touch one flag; idle takes one clock
// RQ13 - flag updates are visible to the very next instruction
module sfi_core (
   // clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst,
   // instruction from decoder
   input  wire logic                           op_valid,
   input  wire sfi_pkg::sfi_op_t               op_code,
   input  wire logic [sfi_pkg::BIT_IDX_W-1:0]  op_bit,
   input  wire logic [sfi_pkg::DATA_W-1:0]     op_src,
   // results to core
   output logic      [sfi_pkg::DATA_W-1:0]     status_flags,
   output logic      [sfi_pkg::DATA_W-1:0]     result_data,
   output logic                                result_we,
   output logic                                op_done,
   output logic                                sleep_req,
   output logic                                watchdog_restart,
   output logic                                break_req,
   // avalon-mm slave
   input  wire logic [sfi_pkg::ADDR_W-1:0]     avs_address,
   input  wire logic                           avs_read,
   input  wire logic                           avs_write,
   input  wire logic [sfi_pkg::BUS_W-1:0]      avs_writedata,
   input  wire logic [sfi_pkg::BE_W-1:0]       avs_byteenable,
   output logic      [sfi_pkg::BUS_W-1:0]      avs_readdata,
   output logic                                avs_waitrequest
);
   import sfi_pkg::*;

   // flag registers and outputs
   logic [DATA_W-1:0] status_flags_reg;
   logic [DATA_W-1:0] status_flags_next;
   logic [DATA_W-1:0] result_data_reg;
   logic              result_we_reg;
   logic              op_done_reg;
   logic              sleep_req_reg;
   logic              watchdog_restart_reg;
   logic              break_req_reg;

   // software-visible state
   logic [DATA_W-1:0] ctrl_reg;
   logic [OP_W-1:0]   last_op_reg;
   logic [DATA_W-1:0] count_reg;
   logic [BUS_W-1:0]  readdata_reg;
   logic              waitrequest_reg;

   // decode results
   logic              flag_we;
   logic [2:0]        flag_idx;
   logic              flag_val;
   logic              picked_bit;
   logic [DATA_W-1:0] merged_data;

   // bus decode
   wire               bus_req;
   wire               bus_ack;
   wire               bus_wr_lane0;
   wire               status_wr;
   wire               ctrl_wr;
   wire               debug_en;
   wire               is_break;
   wire               break_taken;
   wire [DATA_W-1:0]  flags_base;
   wire [DATA_W-1:0]  flag_onehot;
   wire [BUS_W-1:0]   rd_mux;

   // bit select and insert for copy and load
   sfi_bit_unit i_sfi_bit_unit (
      .src_data      (op_src),
      .bit_idx       (op_bit),
      .transfer_flag (status_flags_reg[FLAG_T]),
      .picked_bit    (picked_bit),
      .merged_data   (merged_data)
   );

   // which flag an instruction writes, and with what
   always_comb begin
      {flag_we, flag_idx, flag_val} = {1'b0, FLAG_C, 1'b0};
      case (op_code)
         OP_SET_BY_INDEX:     {flag_we, flag_idx, flag_val} = {1'b1, op_bit, 1'b1}; // RQ12
         OP_CLEAR_BY_INDEX:   {flag_we, flag_idx, flag_val} = {1'b1, op_bit, 1'b0}; // RQ12
         OP_SET_CARRY:        {flag_we, flag_idx, flag_val} = {1'b1, FLAG_C, 1'b1}; // RQ12
         OP_CLEAR_CARRY:      {flag_we, flag_idx, flag_val} = {1'b1, FLAG_C, 1'b0}; // RQ12
         OP_SET_NEGATIVE:     {flag_we, flag_idx, flag_val} = {1'b1, FLAG_N, 1'b1}; // RQ12
         OP_CLEAR_NEGATIVE:   {flag_we, flag_idx, flag_val} = {1'b1, FLAG_N, 1'b0}; // RQ12
         OP_SET_ZERO:         {flag_we, flag_idx, flag_val} = {1'b1, FLAG_Z, 1'b1}; // RQ12
         OP_CLEAR_ZERO:       {flag_we, flag_idx, flag_val} = {1'b1, FLAG_Z, 1'b0}; // RQ12
         OP_IRQ_ON:           {flag_we, flag_idx, flag_val} = {1'b1, FLAG_I, 1'b1}; // RQ12
         OP_IRQ_OFF:          {flag_we, flag_idx, flag_val} = {1'b1, FLAG_I, 1'b0}; // RQ12
         OP_SET_SIGN:         {flag_we, flag_idx, flag_val} = {1'b1, FLAG_S, 1'b1}; // RQ3
         OP_CLEAR_SIGN:       {flag_we, flag_idx, flag_val} = {1'b1, FLAG_S, 1'b0}; // RQ4
         OP_SET_OVERFLOW:     {flag_we, flag_idx, flag_val} = {1'b1, FLAG_V, 1'b1}; // RQ5
         OP_CLEAR_OVERFLOW:   {flag_we, flag_idx, flag_val} = {1'b1, FLAG_V, 1'b0}; // RQ6
         OP_SET_TRANSFER:     {flag_we, flag_idx, flag_val} = {1'b1, FLAG_T, 1'b1}; // RQ12
         OP_CLEAR_TRANSFER:   {flag_we, flag_idx, flag_val} = {1'b1, FLAG_T, 1'b0}; // RQ12
         OP_SET_HALF_CARRY:   {flag_we, flag_idx, flag_val} = {1'b1, FLAG_H, 1'b1}; // RQ7
         OP_CLEAR_HALF_CARRY: {flag_we, flag_idx, flag_val} = {1'b1, FLAG_H, 1'b0}; // RQ8
         OP_COPY_BIT:         {flag_we, flag_idx, flag_val} = {1'b1, FLAG_T, picked_bit}; // RQ1
         default:             {flag_we, flag_idx, flag_val} = {1'b0, FLAG_C, 1'b0};
      endcase
      if (!op_valid) begin
         flag_we = 1'b0;
      end
   end

   // bus decode
   assign bus_req      = avs_read | avs_write;
   assign bus_ack      = bus_req & ~waitrequest_reg;
   assign bus_wr_lane0 = bus_ack & avs_write & avs_byteenable[0];
   assign status_wr    = bus_wr_lane0 & (avs_address == REG_STATUS_IDX);
   assign ctrl_wr      = bus_wr_lane0 & (avs_address == REG_CTRL_IDX);
   assign debug_en     = ctrl_reg[CTRL_DEBUG_EN_BIT];
   assign is_break     = op_valid & (op_code == OP_BREAK);
   assign break_taken  = is_break & debug_en; // RQ11

   // software write lands first, the instruction's flag on top of it
   assign flags_base        = status_wr ? avs_writedata[DATA_W-1:0]
                                        : status_flags_reg;
   assign flag_onehot       = 8'h01 << flag_idx;
   assign status_flags_next = flag_we
      ? ((flags_base & ~flag_onehot) | (flag_val ? flag_onehot : 8'h00))
      : flags_base; // RQ12

   // read data selection, unmapped words read zero
   assign rd_mux =
      (avs_address == REG_STATUS_IDX) ? {24'h000000, status_flags_reg} :
      (avs_address == REG_CTRL_IDX)   ? {24'h000000, ctrl_reg} :
      (avs_address == REG_INFO_IDX)   ? {16'h0000, count_reg,
                                         3'h0, last_op_reg} :
      32'h00000000;

   // status register, written back in the same clock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_flags_reg <= STATUS_RESET;
      end else begin
         status_flags_reg <= status_flags_next; // RQ13
      end
   end

   // instruction side outputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         result_data_reg      <= 8'h00;
         result_we_reg        <= 1'b0;
         op_done_reg          <= 1'b0;
         sleep_req_reg        <= 1'b0;
         watchdog_restart_reg <= 1'b0;
         break_req_reg        <= 1'b0;
      end else begin
         result_data_reg      <= merged_data; // RQ2
         result_we_reg        <= op_valid & (op_code == OP_LOAD_BIT); // RQ2
         op_done_reg          <= op_valid & ~break_taken; // RQ12
         sleep_req_reg        <= op_valid & (op_code == OP_SLEEP); // RQ9
         watchdog_restart_reg <= op_valid
                                 & (op_code == OP_WATCHDOG_RESTART); // RQ10
         break_req_reg        <= break_taken; // RQ11
      end
   end

   // software registers and execution record
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg    <= CTRL_RESET;
         last_op_reg <= OP_IDLE;
         count_reg   <= COUNT_RESET;
      end else begin
         if (ctrl_wr) begin
            ctrl_reg <= avs_writedata[DATA_W-1:0];
         end
         if (op_valid) begin
            last_op_reg <= op_code;
            count_reg   <= count_reg + 8'h01;
         end
      end
   end

   // one wait state per access, then a single ready cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         waitrequest_reg <= 1'b1;
         readdata_reg    <= 32'h00000000;
      end else begin
         waitrequest_reg <= ~(bus_req & waitrequest_reg);
         if (avs_read & waitrequest_reg) begin
            readdata_reg <= rd_mux;
         end
      end
   end

   assign status_flags     = status_flags_reg;
   assign result_data      = result_data_reg;
   assign result_we        = result_we_reg;
   assign op_done          = op_done_reg;
   assign sleep_req        = sleep_req_reg;
   assign watchdog_restart = watchdog_restart_reg;
   assign break_req        = break_req_reg;
   assign avs_readdata     = readdata_reg;
   assign avs_waitrequest  = waitrequest_reg;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic [DATA_W-1:0] prev_flags_reg;
   wire  [DATA_W-1:0] flag_delta;
   wire               op_plain;

   // flags of the cycle before, for the one-flag checks
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_flags_reg <= STATUS_RESET;
      end else begin
         prev_flags_reg <= status_flags_reg;
      end
   end

   assign flag_delta = status_flags_reg ^ prev_flags_reg;
   assign op_plain   = op_valid & ~status_wr;

   a_copy_transfer: assert property ( // RQ1
      op_plain && op_code == OP_COPY_BIT |=>
         status_flags_reg[FLAG_T] == $past(op_src[op_bit]) &&
         (flag_delta & 8'hBF) == 8'h00 && op_done_reg)
      else $error("bit copy did not move the source bit into transfer");

   a_load_result: assert property ( // RQ2
      op_plain && op_code == OP_LOAD_BIT |=>
         result_we_reg && flag_delta == 8'h00 &&
         result_data_reg[$past(op_bit)] == $past(status_flags_reg[FLAG_T]) &&
         ((result_data_reg ^ $past(op_src)) & ~(8'h01 << $past(op_bit)))
            == 8'h00
         ##1 !result_we_reg || $past(op_valid && op_code == OP_LOAD_BIT))
      else $error("bit load result or flags wrong");

   a_sign_set: assert property ( // RQ3
      op_plain && op_code == OP_SET_SIGN |=>
         status_flags_reg[FLAG_S] && (flag_delta & 8'hEF) == 8'h00)
      else $error("set sign did not force only the signed test flag");

   a_sign_clear: assert property ( // RQ4
      op_plain && op_code == OP_CLEAR_SIGN |=>
         !status_flags_reg[FLAG_S] && (flag_delta & 8'hEF) == 8'h00)
      else $error("clear sign did not clear only the signed test flag");

   a_ovf_set: assert property ( // RQ5
      op_plain && op_code == OP_SET_OVERFLOW |=>
         status_flags_reg[FLAG_V] && (flag_delta & 8'hF7) == 8'h00)
      else $error("set overflow disturbed another flag");

   a_ovf_clear: assert property ( // RQ6
      op_plain && op_code == OP_CLEAR_OVERFLOW |=>
         !status_flags_reg[FLAG_V] && (flag_delta & 8'hF7) == 8'h00)
      else $error("clear overflow disturbed another flag");

   a_half_set: assert property ( // RQ7
      op_plain && op_code == OP_SET_HALF_CARRY |=>
         status_flags_reg[FLAG_H] && (flag_delta & 8'hDF) == 8'h00)
      else $error("set half carry disturbed another flag");

   a_half_clear: assert property ( // RQ8
      op_plain && op_code == OP_CLEAR_HALF_CARRY |=>
         !status_flags_reg[FLAG_H] && (flag_delta & 8'hDF) == 8'h00)
      else $error("clear half carry disturbed another flag");

   a_sleep_pulse: assert property ( // RQ9
      op_plain && op_code == OP_SLEEP |=>
         sleep_req_reg && op_done_reg && $stable(status_flags_reg))
      else $error("sleep did not pulse sleep request in one clock");

   a_wdog_pulse: assert property ( // RQ10
      op_plain && op_code == OP_WATCHDOG_RESTART |=>
         watchdog_restart_reg && op_done_reg && flag_delta == 8'h00)
      else $error("watchdog restart did not pulse in one clock");

   a_break_gate: assert property ( // RQ11
      is_break && !status_wr |=>
         break_req_reg == $past(debug_en) && !op_done_reg == $past(debug_en)
         && flag_delta == 8'h00)
      else $error("break request not gated by debug enable");

   a_index_one: assert property ( // RQ12
      op_plain && (op_code == OP_SET_BY_INDEX ||
                   op_code == OP_CLEAR_BY_INDEX) |=>
         status_flags_reg[$past(op_bit)] ==
            ($past(op_code) == OP_SET_BY_INDEX) &&
         (flag_delta & ~(8'h01 << $past(op_bit))) == 8'h00)
      else $error("indexed flag op touched the wrong flag");

   a_next_sees: assert property ( // RQ13
      flag_we && !status_wr ##1 op_valid |->
         status_flags_reg[$past(flag_idx)] == $past(flag_val))
      else $error("following instruction does not see updated flag");

   a_bus_answer: assert property (
      bus_req && waitrequest_reg |=> !waitrequest_reg ##1 waitrequest_reg)
      else $error("bus answer not given after one wait state");

   c_copy_then_load: cover property (
      op_valid && op_code == OP_COPY_BIT ##1
      op_valid && op_code == OP_LOAD_BIT);
   c_sleep: cover property (op_valid && op_code == OP_SLEEP ##1 sleep_req_reg);
   c_break_debug: cover property (break_taken ##1 break_req_reg);
   c_bus_and_op: cover property (status_wr && flag_we);

endmodule

// [dv/sfi_core_tb.sv]
// Purpose: self-checking bench for the status flag instruction unit
// Assumes: registered outputs one cycle after each taken op
// Notes:   flag model runs beside the design, checks at falling edge
`timescale 1ns/1ps
module sfi_core_tb;
   import sfi_pkg::*;
   logic              clk = 1'b0;
   logic              rst;
   logic              op_valid;
   sfi_op_t           op_code;
   logic [2:0]        op_bit;
   logic [7:0]        op_src;
   logic [7:0]        status_flags;
   logic [7:0]        result_data;
   logic              result_we;
   logic              op_done;
   logic              sleep_req;
   logic              watchdog_restart;
   logic              break_req;
   logic [1:0]        avs_address;
   logic              avs_read;
   logic              avs_write;
   logic [31:0]       avs_writedata;
   logic [3:0]        avs_byteenable;
   logic [31:0]       avs_readdata;
   logic              avs_waitrequest;
   int                n_mismatch = 0;
   int                total_checks = 0;
   int                cycles = 0;
   integer            seed = 32'hF91A9A95;
   logic [31:0]       rd;
   logic [31:0]       r;
   logic [7:0]        m_flags, m_res, m_cnt;
   logic [4:0]        m_last;
   logic              m_dbg, m_pend, m_we, m_done, m_slp, m_wdr, m_brk;
   logic [2:0]        fpos [8] = '{FLAG_C, FLAG_N, FLAG_Z, FLAG_I,
                                   FLAG_S, FLAG_V, FLAG_T, FLAG_H};

   sfi_core i_sfi_core (
      .clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
      .op_bit(op_bit), .op_src(op_src), .status_flags(status_flags),
      .result_data(result_data), .result_we(result_we),
      .op_done(op_done), .sleep_req(sleep_req),
      .watchdog_restart(watchdog_restart), .break_req(break_req),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));

   always #5 clk = ~clk;

   task finish_test;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         $display("MISMATCH run_length expected below 20000 seen 20000");
         finish_test();
      end
   end

   task chk_val(input string what, input logic [31:0] exp,
                input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task chk_bit(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask

   task check_out;
      chk_val("status_flags", m_flags, status_flags);
      chk_bit("op_done", m_done, op_done);
      chk_bit("result_we", m_we, result_we);
      if (m_we) chk_val("result_data", m_res, result_data);
      chk_bit("sleep_req", m_slp, sleep_req);
      chk_bit("watchdog_restart", m_wdr, watchdog_restart);
      chk_bit("break_req", m_brk, break_req);
   endtask

   // expected effect of one op on the flag model
   task model(input logic v, input logic [4:0] c, input logic [2:0] b,
              input logic [7:0] s);
      {m_we, m_slp, m_wdr, m_brk} = 4'h0;
      m_done = v;
      if (v) begin
         m_cnt = m_cnt + 8'h01;
         m_last = c;
         if (c == OP_SET_BY_INDEX) m_flags[b] = 1'b1;
         if (c == OP_CLEAR_BY_INDEX) m_flags[b] = 1'b0;
         if (c >= OP_SET_CARRY && c <= OP_CLEAR_HALF_CARRY)
            m_flags[fpos[(c - OP_SET_CARRY) >> 1]] = c[0];
         if (c == OP_COPY_BIT) m_flags[FLAG_T] = s[b];
         if (c == OP_LOAD_BIT) begin
            m_we = 1'b1;
            m_res = s;
            m_res[b] = m_flags[FLAG_T];
         end
         m_slp = (c == OP_SLEEP);
         m_wdr = (c == OP_WATCHDOG_RESTART);
         if (c == OP_BREAK && m_dbg) begin
            m_brk = 1'b1;
            m_done = 1'b0;
         end
      end
   endtask

   // drive one op, check the outputs of the op before it
   task issue(input logic v, input logic [4:0] c, input logic [2:0] b,
              input logic [7:0] s);
      @(posedge clk);
      op_valid <= v;
      op_code <= sfi_op_t'(c);
      op_bit <= b;
      op_src <= s;
      @(negedge clk);
      if (m_pend) check_out();
      model(v, c, b, s);
      m_pend = 1'b1;
   endtask

   task bus(input logic wr, input logic [1:0] a, input logic [31:0] d,
            input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      if (wr) avs_write <= 1'b1;
      else avs_read <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      chk_val("wait_edges", 32'h2, n);
      if (wr && be[0] && a == REG_STATUS_IDX) m_flags = d[7:0];
      if (wr && be[0] && a == REG_CTRL_IDX) m_dbg = d[0];
   endtask

   task rd_chk(input logic [1:0] a, input logic [31:0] exp, input string nm);
      bus(1'b0, a, 32'h0, 4'hF);
      chk_val(nm, exp, rd);
   endtask

   task do_reset;
      @(posedge clk);
      rst <= 1'b1;
      op_valid <= 1'b0;
      repeat (5) @(posedge clk);
      chk_bit("avs_waitrequest", 1'b1, avs_waitrequest);
      chk_val("status_flags", STATUS_RESET, status_flags);
      rst <= 1'b0;
      m_flags = STATUS_RESET;
      {m_dbg, m_pend, m_cnt, m_last} = 15'h0;
   endtask

   initial begin
      rst = 1'b1;
      op_valid = 1'b0;
      op_code = OP_IDLE;
      op_bit = 3'h0;
      op_src = 8'h00;
      avs_address = 2'h0;
      {avs_read, avs_write} = 2'h0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      do_reset();
      rd_chk(REG_STATUS_IDX, 32'h0, "status_reg");
      rd_chk(REG_CTRL_IDX, 32'h0, "control_reg");
      rd_chk(REG_INFO_IDX, 32'h0, "info_reg");
      $display("test reset_values done");
      // every code back to back, from all-clear and all-set flags
      for (int p = 0; p < 2; p++) begin
         bus(1'b1, REG_STATUS_IDX, p ? 32'hFF : 32'h00, 4'h1);
         for (int c = 0; c < 32; c++) begin
            r = $random(seed);
            issue(1'b1, c[4:0], r[2:0], r[10:3]);
         end
         issue(1'b0, 5'h0, 3'h0, 8'h00);
      end
      $display("test all_codes done");
      // break with the debugger attached
      bus(1'b1, REG_CTRL_IDX, 32'h1, 4'h1);
      rd_chk(REG_CTRL_IDX, 32'h1, "control_reg");
      issue(1'b1, OP_BREAK, 3'h0, 8'h00);
      issue(1'b1, OP_BREAK, 3'h0, 8'h00);
      issue(1'b1, OP_SET_SIGN, 3'h0, 8'h00);
      issue(1'b0, 5'h0, 3'h0, 8'h00);
      $display("test debug_break done");
      // random traffic, debug enable toggled now and then
      for (int i = 0; i < 400; i++) begin
         r = $random(seed);
         issue(r[0] | r[1], r[6:2], r[9:7], r[17:10]);
         if (i % 50 == 49) begin
            issue(1'b0, 5'h0, 3'h0, 8'h00);
            bus(1'b1, REG_CTRL_IDX, r, 4'h1);
            bus(1'b1, REG_STATUS_IDX, {r[31:24], r[31:24], r[7:0], r[31:24]}, r[23:20]);
         end
      end
      issue(1'b0, 5'h0, 3'h0, 8'h00);
      $display("test random_ops done");
      // bus corner cases
      bus(1'b1, REG_STATUS_IDX, 32'hFFFF_FF3C, 4'hE);
      rd_chk(REG_STATUS_IDX, {24'h0, m_flags}, "status_reg");
      bus(1'b1, REG_STATUS_IDX, 32'hFFFF_FF3C, 4'hF);
      rd_chk(REG_STATUS_IDX, 32'h3C, "status_reg");
      bus(1'b1, 2'h3, 32'hFFFF_FFFF, 4'hF);
      rd_chk(2'h3, 32'h0, "unmapped_reg");
      issue(1'b1, OP_CLEAR_OVERFLOW, 3'h0, 8'h00);
      issue(1'b1, OP_SET_OVERFLOW, 3'h0, 8'h00);
      issue(1'b0, 5'h0, 3'h0, 8'h00);
      $display("test bus_corners done");
      // reset in mid run, then count and last code
      issue(1'b1, OP_SET_CARRY, 3'h0, 8'h00);
      do_reset();
      issue(1'b1, OP_SET_HALF_CARRY, 3'h0, 8'h00);
      issue(1'b1, OP_COPY_BIT, 3'h3, 8'h08);
      issue(1'b1, OP_LOAD_BIT, 3'h0, 8'h00);
      issue(1'b0, 5'h0, 3'h0, 8'h00);
      bus(1'b1, REG_INFO_IDX, 32'hFFFF_FFFF, 4'hF);
      rd_chk(REG_INFO_IDX, {16'h0, m_cnt, 3'h0, m_last}, "info_reg");
      issue(1'b1, OP_CLEAR_HALF_CARRY, 3'h0, 8'h00);
      issue(1'b0, 5'h0, 3'h0, 8'h00);
      issue(1'b0, 5'h0, 3'h0, 8'h00);
      $display("test mid_reset done");
      finish_test();
   end
endmodule
